/* File: rtl/can_filter_mask_and_msg_buffer.sv */
`timescale 1ns/100ps
module can_filter_mask_and_msg_buffer #(
  parameter int num_buffers = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  input wire can_filt_pkg::rx_msg_t rx_msg,
  output logic fifo_valid,
  output can_filt_pkg::fifo_msg_t fifo_msg,
  output logic rx_dropped
);
  import can_filt_pkg::*;

  // software-visible control and status state
  logic [15:0] mask_source_select;
  logic [31:0] buffer_pointer;
  logic [10:0] mask0;
  logic [10:0] mask1;
  logic [10:0] mask2;
  logic [7:0] filter_enable;
  logic [15:0] tx_buffer_flags;
  logic [5:0] last_hit;
  logic [10:0] filter_id [filter_count];
  logic [15:0] word6 [num_buffers];
  logic [4:0] hit_code [num_buffers];

  // mask for one filter from its two-bit source code
  function automatic logic [10:0] pick_mask(input logic [1:0] code, input logic [10:0] m0,
                                            input logic [10:0] m1, input logic [10:0] m2);
    case (code)
      src_mask0: pick_mask = m0;
      src_mask1: pick_mask = m1;
      src_mask2: pick_mask = m2;
      default: pick_mask = 11'h7ff;
    endcase
  endfunction

  // two-bit mask source field of the filter at position idx
  function automatic logic [1:0] source_of(input logic [15:0] sel, input int idx);
    source_of = sel[mask_source_width*idx +: mask_source_width];
  endfunction

  // hit code for the filter at position idx above the first filter
  function automatic logic [4:0] hit_of(input logic [2:0] idx);
    hit_of = 5'(filter_first) + {2'h0, idx};
  endfunction

  // four-bit buffer pointer of the filter at position idx
  function automatic logic [3:0] pointer_of(input logic [31:0] ptrs, input logic [2:0] idx);
    pointer_of = ptrs[buffer_pointer_width*idx +: buffer_pointer_width];
  endfunction

  // apb decode
  logic wr_en;
  logic rd_en;
  logic in_filter_ids;
  logic in_buffers;
  logic [2:0] filt_idx;
  logic [3:0] buf_idx;
  logic word_sel;
  logic mapped;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !pwrite;
  assign in_filter_ids = paddr[11:5] == off_filter_id_base[11:5] && paddr[1:0] == 2'h0;
  assign in_buffers = paddr[11:8] == off_msg_buffer_base[11:8] && paddr[1:0] == 2'h0
                      && int'(paddr[7:3]) < num_buffers;
  assign filt_idx = paddr[4:2];
  assign buf_idx = paddr[6:3];
  assign word_sel = paddr[2];
  assign pready = 1'b1;

  // address map check for the slave error
  always_comb begin
    mapped = 1'b1;
    case (paddr)
      off_mask_source_select, off_buffer_pointer, off_mask0, off_mask1, off_mask2,
      off_filter_enable, off_tx_buffer_flags, off_last_hit: mapped = 1'b1;
      default: mapped = in_filter_ids || in_buffers;
    endcase
  end

  // per-filter compare: enabled, legal source code, id equal where the mask is set
  logic [7:0] filter_hits;
  always_comb begin
    logic [1:0] code;
    logic [10:0] m;
    code = src_mask0;
    m = 11'h000;
    filter_hits = 8'h00;
    for (int i = 0; i < filter_count; i++) begin
      code = source_of(mask_source_select, i);
      m = pick_mask(code, mask0, mask1, mask2);
      filter_hits[i] = filter_enable[i] && code != src_reserved
                       && ((rx_msg.id ^ filter_id[i]) & m) == 11'h000;
    end
  end

  // lowest filter number wins when several match
  logic match_any;
  logic [2:0] match_idx;
  logic [1:0] match_src;
  always_comb begin
    match_any = 1'b0;
    match_idx = 3'h0;
    for (int i = filter_count - 1; i >= 0; i--) begin
      if (filter_hits[i]) begin
        match_any = 1'b1;
        match_idx = 3'(i);
      end
    end
  end
  assign match_src = source_of(mask_source_select, int'(match_idx));

  // routing of the winning filter's frame
  logic accept;
  logic [3:0] route;
  logic [4:0] hit_number;
  logic to_fifo;
  logic to_buffer;
  assign accept = rx_valid && match_any;
  assign route = pointer_of(buffer_pointer, match_idx);
  assign hit_number = hit_of(match_idx);
  assign to_fifo = accept && route == pointer_to_fifo;
  assign to_buffer = accept && route != pointer_to_fifo && int'(route) < num_buffers
                     && !tx_buffer_flags[route];

  // control registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_source_select <= rst_mask_source_select;
      buffer_pointer <= rst_buffer_pointer;
      mask0 <= rst_mask;
      mask1 <= rst_mask;
      mask2 <= rst_mask;
      filter_enable <= rst_filter_enable;
      tx_buffer_flags <= rst_tx_buffer_flags;
    end else if (wr_en) begin
      case (paddr)
        off_mask_source_select: mask_source_select <= pwdata[15:0];
        off_buffer_pointer: buffer_pointer <= pwdata;
        off_mask0: mask0 <= pwdata[10:0];
        off_mask1: mask1 <= pwdata[10:0];
        off_mask2: mask2 <= pwdata[10:0];
        off_filter_enable: filter_enable <= pwdata[7:0];
        off_tx_buffer_flags: tx_buffer_flags <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // filter identifiers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < filter_count; i++) filter_id[i] <= rst_filter_id;
    end else if (wr_en && in_filter_ids) begin
      filter_id[filt_idx] <= pwdata[10:0];
    end
  end

  // message buffers, no reset; a stored frame overrides a same-cycle write
  always_ff @(posedge clk) begin
    if (wr_en && in_buffers) begin
      if (!word_sel) word6[buf_idx] <= pwdata[15:0];
      else hit_code[buf_idx] <= pwdata[hit_msb:hit_lsb];
    end
    if (to_buffer) begin
      word6[route] <= {rx_msg.byte7, rx_msg.byte6};
      hit_code[route] <= hit_number;
    end
  end

  // fifo hand-off and status
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fifo_valid <= 1'b0;
      fifo_msg <= '0;
      rx_dropped <= 1'b0;
      last_hit <= 6'h00;
    end else begin
      fifo_valid <= to_fifo;
      rx_dropped <= rx_valid && !(to_fifo || to_buffer);
      if (to_fifo) fifo_msg <= '{hit: hit_number, id: rx_msg.id, byte7: rx_msg.byte7,
                                  byte6: rx_msg.byte6};
      if (accept) last_hit <= {1'b1, hit_number};
    end
  end

  // read mux
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= 32'h0000_0000;
      if (rd_en && !penable) begin
        case (paddr)
          off_mask_source_select: prdata <= {16'h0000, mask_source_select};
          off_buffer_pointer: prdata <= buffer_pointer;
          off_mask0: prdata <= {21'h0, mask0};
          off_mask1: prdata <= {21'h0, mask1};
          off_mask2: prdata <= {21'h0, mask2};
          off_filter_enable: prdata <= {24'h0, filter_enable};
          off_tx_buffer_flags: prdata <= {16'h0000, tx_buffer_flags};
          off_last_hit: prdata <= {26'h0, last_hit};
          default: begin
            if (in_filter_ids) prdata <= {21'h0, filter_id[filt_idx]};
            else if (in_buffers && !word_sel) prdata <= {16'h0000, word6[buf_idx]};
            else if (in_buffers) prdata <= {19'h0, hit_code[buf_idx], 8'h00};
          end
        endcase
      end else if (psel && penable && !pwrite) begin
        prdata <= prdata;
      end
    end
  end

  // slave error only in the access phase of an unmapped address
  assign pslverr = psel && penable && !mapped;

  // mask selection and filter priority
  a_mask_zero_pick: assert property (@(posedge clk) disable iff (rst)
    accept && match_src == src_mask0 |-> ((rx_msg.id ^ filter_id[match_idx]) & mask0) == 11'h0)
    else $error("accepted frame differs from filter under mask 0");
  a_mask_one_pick: assert property (@(posedge clk) disable iff (rst)
    accept && match_src == src_mask1 |-> ((rx_msg.id ^ filter_id[match_idx]) & mask1) == 11'h0)
    else $error("accepted frame differs from filter under mask 1");
  a_mask_two_pick: assert property (@(posedge clk) disable iff (rst)
    accept && match_src == src_mask2 |-> ((rx_msg.id ^ filter_id[match_idx]) & mask2) == 11'h0)
    else $error("accepted frame differs from filter under mask 2");
  a_reserved_no_hit: assert property (@(posedge clk) disable iff (rst)
    accept |-> source_of(mask_source_select, int'(match_idx)) != src_reserved)
    else $error("filter with reserved mask source accepted a frame");
  a_lowest_filter_wins: assert property (@(posedge clk) disable iff (rst)
    accept |-> (filter_hits & ((8'h01 << match_idx) - 8'h01)) == 8'h00)
    else $error("a lower numbered filter also matched the frame");
  a_enabled_filter_hit: assert property (@(posedge clk) disable iff (rst)
    accept |-> filter_enable[match_idx])
    else $error("disabled filter accepted a frame");
  a_unmatched_dropped: assert property (@(posedge clk) disable iff (rst)
    rx_valid && !accept |=> rx_dropped)
    else $error("frame with no matching filter not reported as dropped");

  // message buffer storage
  a_word6_stored: assert property (@(posedge clk) disable iff (rst)
    to_buffer |=> word6[$past(route)] == {$past(rx_msg.byte7), $past(rx_msg.byte6)})
    else $error("payload bytes not stored in word 6");
  a_hit_code_stored: assert property (@(posedge clk) disable iff (rst)
    to_buffer |=> hit_code[$past(route)] == hit_of($past(match_idx)))
    else $error("hit code does not name the accepting filter");
  a_tx_not_written: assert property (@(posedge clk) disable iff (rst)
    to_buffer |-> !tx_buffer_flags[route])
    else $error("transmit buffer written by receive path");
  a_tx_hit_kept: assert property (@(posedge clk) disable iff (rst)
    accept && route != pointer_to_fifo && tx_buffer_flags[route] && !(wr_en && in_buffers)
    |=> hit_code[$past(route)] == $past(hit_code[route]))
    else $error("hardware changed the hit code of a transmit buffer");
  a_word6_sw_write: assert property (@(posedge clk) disable iff (rst)
    wr_en && in_buffers && !word_sel && !(to_buffer && route == buf_idx)
    |=> word6[$past(buf_idx)] == $past(pwdata[15:0]))
    else $error("software write to word 6 lost");
  a_hit_sw_write: assert property (@(posedge clk) disable iff (rst)
    wr_en && in_buffers && word_sel && !(to_buffer && route == buf_idx)
    |=> hit_code[$past(buf_idx)] == $past(pwdata[hit_msb:hit_lsb]))
    else $error("software write to the hit field lost");

  // fifo hand-off and status
  a_fifo_route: assert property (@(posedge clk) disable iff (rst)
    accept && route == pointer_to_fifo |=> fifo_valid && fifo_msg.id == $past(rx_msg.id))
    else $error("frame for fifo not handed over");
  a_fifo_payload: assert property (@(posedge clk) disable iff (rst)
    to_fifo |=> fifo_msg.byte7 == $past(rx_msg.byte7)
                && fifo_msg.byte6 == $past(rx_msg.byte6))
    else $error("fifo payload bytes differ from the frame");
  a_fifo_hit_code: assert property (@(posedge clk) disable iff (rst)
    to_fifo |=> fifo_msg.hit == hit_of($past(match_idx)))
    else $error("fifo hit code does not name the accepting filter");
  a_fifo_pulse_only: assert property (@(posedge clk) disable iff (rst)
    !to_fifo |=> !fifo_valid)
    else $error("fifo valid without a frame routed to the fifo");
  a_fifo_msg_hold: assert property (@(posedge clk) disable iff (rst)
    !to_fifo |=> fifo_msg == $past(fifo_msg))
    else $error("fifo frame changed without a new frame");
  a_last_hit_code: assert property (@(posedge clk) disable iff (rst)
    accept |=> last_hit == {1'b1, hit_of($past(match_idx))})
    else $error("last hit register does not name the accepting filter");

  // register read data
  a_sel_readback: assert property (@(posedge clk) disable iff (rst)
    psel && !penable && !pwrite && paddr == off_mask_source_select
    |=> prdata == {16'h0000, $past(mask_source_select)})
    else $error("mask source select read data wrong");
  a_word6_read_path: assert property (@(posedge clk) disable iff (rst)
    psel && !penable && !pwrite && in_buffers && !word_sel
    |=> prdata == {16'h0000, $past(word6[buf_idx])})
    else $error("word 6 read data wrong");
  a_word7_read_path: assert property (@(posedge clk) disable iff (rst)
    psel && !penable && !pwrite && in_buffers && word_sel
    |=> prdata == {19'h0, $past(hit_code[buf_idx]), 8'h00})
    else $error("word 7 read data wrong");
endmodule

/* File: common/can_filt_pkg.sv */
package can_filt_pkg;
  // register byte offsets
  localparam logic [11:0] off_mask_source_select = 12'h000;
  localparam logic [11:0] off_buffer_pointer = 12'h004;
  localparam logic [11:0] off_mask0 = 12'h008;
  localparam logic [11:0] off_mask1 = 12'h00c;
  localparam logic [11:0] off_mask2 = 12'h010;
  localparam logic [11:0] off_filter_enable = 12'h014;
  localparam logic [11:0] off_tx_buffer_flags = 12'h018;
  localparam logic [11:0] off_last_hit = 12'h01c;
  localparam logic [11:0] off_filter_id_base = 12'h040;
  localparam logic [11:0] off_msg_buffer_base = 12'h100;
  // field layout
  localparam int mask_source_width = 2;
  localparam int buffer_pointer_width = 4;
  localparam int filter_first = 8;
  localparam int filter_count = 8;
  localparam int hit_lsb = 8;
  localparam int hit_msb = 12;
  localparam logic [3:0] pointer_to_fifo = 4'hf;
  // mask source codes
  localparam logic [1:0] src_mask0 = 2'h0;
  localparam logic [1:0] src_mask1 = 2'h1;
  localparam logic [1:0] src_mask2 = 2'h2;
  localparam logic [1:0] src_reserved = 2'h3;
  // reset values
  localparam logic [15:0] rst_mask_source_select = 16'h0000;
  localparam logic [31:0] rst_buffer_pointer = 32'h0000_0000;
  localparam logic [10:0] rst_mask = 11'h000;
  localparam logic [7:0] rst_filter_enable = 8'h00;
  localparam logic [15:0] rst_tx_buffer_flags = 16'h0000;
  localparam logic [10:0] rst_filter_id = 11'h000;

  // received frame handed over by the protocol engine
  typedef struct packed {
    logic [10:0] id;
    logic [7:0] byte7;
    logic [7:0] byte6;
  } rx_msg_t;

  // frame routed to the receive fifo
  typedef struct packed {
    logic [4:0] hit;
    logic [10:0] id;
    logic [7:0] byte7;
    logic [7:0] byte6;
  } fifo_msg_t;
endpackage

/* File: verif/can_frame_source.sv */
`timescale 1ns/100ps
// stand-in for the protocol engine handing over frames from other bus nodes
module can_frame_source (
  input wire logic clk,
  output logic rx_valid,
  output can_filt_pkg::rx_msg_t rx_msg
);
  import can_filt_pkg::*;
  initial begin
    rx_valid = 1'b0;
    rx_msg = '0;
  end
  // one-cycle frame, then the bus lines show the inverse of the last frame
  task automatic send(input logic [10:0] id, input logic [7:0] b7, input logic [7:0] b6);
    rx_msg_t m;
    m = '{id: id, byte7: b7, byte6: b6};
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_msg <= m;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_msg <= ~m;
    @(negedge clk); // return where the one-cycle answers stand
  endtask
endmodule

/* File: verif/can_filter_mask_and_msg_buffer_tb.sv */
`timescale 1ns/100ps
module can_filter_mask_and_msg_buffer_tb;
  import can_filt_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic rx_valid, fifo_valid, rx_dropped;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  rx_msg_t rx_msg;
  fifo_msg_t fifo_msg;
  int fails = 0;
  int check_count = 0;
  can_filter_mask_and_msg_buffer dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_valid(rx_valid), .rx_msg(rx_msg), .fifo_valid(fifo_valid),
    .fifo_msg(fifo_msg), .rx_dropped(rx_dropped));
  can_frame_source node (.clk(clk), .rx_valid(rx_valid), .rx_msg(rx_msg));
  // clock and time-zero values
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one apb transfer, idle edge first so psel is never set twice in a step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    if (n == 20) fails++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, '0);
    check(name, rd, exp);
  endtask
  task automatic t_reset_and_select();
    rdchk("mask_sel_rst", off_mask_source_select, 32'h0000_0000);
    rdchk("enable_rst", off_filter_enable, 32'h0000_0000);
    apb(1'b1, off_mask_source_select, 32'h0000_9224);
    rdchk("mask_sel", off_mask_source_select, 32'h0000_9224);
  endtask
  // filter 8 id 0x123 to buffer 3; mask code in bits 1-0 picks the mask
  task automatic t_mask_codes();
    logic [1:0] code [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
    logic [10:0] id [4] = '{11'h12a, 11'h12a, 11'h12a, 11'h123};
    apb(1'b1, off_mask0, 32'h0000_07ff);
    apb(1'b1, off_mask1, 32'h0000_07f0);
    apb(1'b1, off_mask2, 32'h0000_0000);
    apb(1'b1, off_filter_id_base, 32'h0000_0123);
    apb(1'b1, off_buffer_pointer, 32'h0000_0003);
    apb(1'b1, off_filter_enable, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, off_mask_source_select, {30'h0, code[i]});
      node.send(id[i], 8'ha0 + 8'(i), 8'h5a);
      check("dropped", {31'h0, rx_dropped}, {31'h0, i == 0});
      if (i != 0) begin
        rdchk("word6", off_msg_buffer_base + 12'h018, {16'h0, 8'ha0 + 8'(i), 8'h5a});
        rdchk("word7", off_msg_buffer_base + 12'h01c, 32'h0000_0800);
      end
    end
  endtask
  task automatic t_pointer_route();
    apb(1'b1, off_buffer_pointer, 32'h0000_000f);
    node.send(11'h123, 8'h11, 8'h22);
    check("fifo_valid", {31'h0, fifo_valid}, 32'h1);
    check("fifo_msg", fifo_msg, {5'd8, 11'h123, 8'h11, 8'h22});
    apb(1'b1, off_buffer_pointer, 32'h0000_000e);
    node.send(11'h123, 8'h33, 8'h44);
    rdchk("word6_b14", off_msg_buffer_base + 12'h070, 32'h0000_3344);
  endtask
  // transmit buffer keeps its hit field; spare bits of word 7 read zero
  task automatic t_tx_buffer();
    apb(1'b1, off_buffer_pointer, 32'h0000_0003);
    apb(1'b1, off_msg_buffer_base + 12'h01c, 32'hffff_f5ff);
    rdchk("word7_bits", off_msg_buffer_base + 12'h01c, 32'h0000_1500);
    apb(1'b1, off_tx_buffer_flags, 32'h0000_0008);
    node.send(11'h123, 8'h77, 8'h66);
    check("tx_drop", {31'h0, rx_dropped}, 32'h1);
    rdchk("word7_tx", off_msg_buffer_base + 12'h01c, 32'h0000_1500);
    apb(1'b0, 12'hffc, '0);
    check("slverr", {31'h0, err}, 32'h1);
    check("unmapped", rd, 32'h0);
  endtask
  // filter 15 via mask 2 to buffer 5; filter 8 holds the reserved code and points to the fifo
  task automatic t_high_filter();
    apb(1'b1, off_filter_id_base + 12'h01c, 32'h0000_03c5);
    apb(1'b1, off_mask_source_select, 32'h0000_8003);
    apb(1'b1, off_buffer_pointer, 32'h5000_000f);
    apb(1'b1, off_filter_enable, 32'h0000_0081);
    node.send(11'h123, 8'h12, 8'h34);
    check("hi_drop", {31'h0, rx_dropped}, 32'h0);
    check("hi_fifo", {31'h0, fifo_valid}, 32'h0);
    rdchk("hi_word6", off_msg_buffer_base + 12'h028, 32'h0000_1234);
    rdchk("hi_word7", off_msg_buffer_base + 12'h02c, 32'h0000_0f00);
    rdchk("hi_last", off_last_hit, 32'h0000_002f);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset_and_select();
    t_mask_codes();
    t_pointer_route();
    t_tx_buffer();
    t_high_filter();
    complete_run();
  end
  // watchdog well beyond the roughly 130 cycles needed
  initial begin
    #100000;
    fails++;
    complete_run();
  end
endmodule
